// ===== rtl/seprog_top.sv
`timescale 1ns/1ps
// serial program/erase controller; serial lines sampled on i_clock
module seprog_top #(
    parameter int PROG_CYCLES = seprog_pkg::PROG_CYCLES
) (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst,
    input  wire logic                          i_chip_select,
    input  wire logic                          i_serial_clock,
    input  wire logic                          i_serial_data_in,
    output logic                               o_serial_data_out,
    output logic                               o_serial_data_out_oe_n,
    output logic                               o_program_enabled,
    output logic                               o_busy,
    input  wire logic [seprog_pkg::ADDR_W-1:0] i_peek_addr,
    output logic      [seprog_pkg::DATA_W-1:0] o_peek_data
);
    typedef enum logic [1:0] {SEP_IDLE, SEP_OPC, SEP_ADR, SEP_DAT} seprog_phase_t;

    localparam int CNT_W = 5;

    seprog_prog_if prog_bus ();

    seprog_phase_t                 phase_r;
    logic [CNT_W-1:0]              cnt_r;
    logic [1:0]                    opc_r;
    logic [seprog_pkg::ADDR_W-1:0] adr_r;
    logic [seprog_pkg::DATA_W-1:0] dat_r;
    logic [4:0]                    nbits_r;
    logic                          sk_d_r;
    logic                          cs_d_r;
    logic                          en_r;
    logic                          status_r;
    logic                          start_r;
    logic                          busy_seen_r;
    seprog_pkg::seprog_cmd_t       cmd_r;
    logic                          sk_rise;
    logic                          cs_fall;
    logic                          cs_rise;
    logic                          accept;
    seprog_pkg::seprog_cmd_t       cmd_nxt;

    ////////////////////////////////////////////////////////////////////////
    // edge detection on the serial pins
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sk_d_r <= 1'b0;
            cs_d_r <= 1'b0;
        end else begin
            sk_d_r <= i_serial_clock;
            cs_d_r <= i_chip_select;
        end
    end

    assign sk_rise = i_serial_clock && !sk_d_r && i_chip_select;
    assign cs_fall = cs_d_r && !i_chip_select;
    assign cs_rise = i_chip_select && !cs_d_r;
    // shifting refused while the array is busy
    assign accept  = sk_rise && !prog_bus.busy;

    ////////////////////////////////////////////////////////////////////////
    // instruction shifter: start, opcode, address, data, msb first
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            phase_r <= SEP_IDLE;
            cnt_r   <= '0;
            opc_r   <= '0;
            adr_r   <= '0;
            dat_r   <= '0;
            nbits_r <= '0;
        end else if (!i_chip_select || prog_bus.busy) begin
            phase_r <= SEP_IDLE;
            cnt_r   <= '0;
            nbits_r <= '0;
        end else if (accept) begin
            case (phase_r)
                SEP_IDLE: begin
                    if (i_serial_data_in) begin
                        phase_r <= SEP_OPC;
                        cnt_r   <= '0;
                    end
                end
                SEP_OPC: begin
                    opc_r <= {opc_r[0], i_serial_data_in};
                    if (cnt_r == CNT_W'(1)) begin
                        phase_r <= SEP_ADR;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + CNT_W'(1);
                    end
                end
                SEP_ADR: begin
                    adr_r <= {adr_r[seprog_pkg::ADDR_W-2:0], i_serial_data_in};
                    if (cnt_r == CNT_W'(seprog_pkg::ADDR_W - 1)) begin
                        phase_r <= SEP_DAT;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + CNT_W'(1);
                    end
                end
                SEP_DAT: begin
                    // extra bits keep shifting; last sixteen remain
                    dat_r <= {dat_r[seprog_pkg::DATA_W-2:0], i_serial_data_in};
                    if (nbits_r != 5'h10) begin
                        nbits_r <= nbits_r + 5'h1;
                    end
                end
                default: begin
                    phase_r <= SEP_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode a completed sequence into a programming job
    always_comb begin
        cmd_nxt = seprog_pkg::SEP_NONE;
        if (phase_r == SEP_DAT && en_r) begin
            case (opc_r)
                seprog_pkg::OP_WRITE: begin
                    if (nbits_r == 5'h10) cmd_nxt = seprog_pkg::SEP_WRITE;
                end
                seprog_pkg::OP_ERASE: begin
                    cmd_nxt = seprog_pkg::SEP_ERASE;
                end
                seprog_pkg::OP_EXT: begin
                    case (adr_r[seprog_pkg::ADDR_W-1 -: 2])
                        seprog_pkg::EXT_WRITE_ALL_WORDS: begin
                            if (nbits_r == 5'h10) cmd_nxt = seprog_pkg::SEP_WRITE_ALL;
                        end
                        seprog_pkg::EXT_ERASE_ALL_WORDS: cmd_nxt = seprog_pkg::SEP_ERASE_ALL;
                        default: cmd_nxt = seprog_pkg::SEP_NONE;
                    endcase
                end
                default: cmd_nxt = seprog_pkg::SEP_NONE;
            endcase
        end
    end

    // launch one job per falling select; refused when disabled
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            start_r <= 1'b0;
            cmd_r   <= seprog_pkg::SEP_NONE;
        end else begin
            start_r <= cs_fall && !prog_bus.busy && cmd_nxt != seprog_pkg::SEP_NONE;
            cmd_r   <= cmd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable latch, cleared at reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            en_r <= 1'b0;
        end else if (cs_fall && phase_r == SEP_DAT && opc_r == seprog_pkg::OP_EXT) begin
            if (adr_r[seprog_pkg::ADDR_W-1 -: 2] == seprog_pkg::EXT_EN) begin
                en_r <= 1'b1;
            end else if (adr_r[seprog_pkg::ADDR_W-1 -: 2] == seprog_pkg::EXT_DIS) begin
                en_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status output after a programming job
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            busy_seen_r <= 1'b0;
        end else if (start_r) begin
            busy_seen_r <= 1'b1;
        end else if (accept && phase_r == SEP_IDLE && i_serial_data_in) begin
            busy_seen_r <= 1'b0;
        end
    end

    // drive only with select high, after a job, until a start bit
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            status_r <= 1'b1;
        end else begin
            status_r <= !(busy_seen_r && i_chip_select && !cs_rise);
        end
    end

    assign o_serial_data_out_oe_n = status_r;
    assign o_serial_data_out      = !prog_bus.busy;
    assign o_program_enabled      = en_r;
    assign o_busy                 = prog_bus.busy;

    assign prog_bus.start = start_r;
    assign prog_bus.cmd   = cmd_r;
    assign prog_bus.addr  = adr_r;
    assign prog_bus.data  = dat_r;

    seprog_array #(
        .PROG_CYCLES (PROG_CYCLES)
    ) u_array (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .prog      (prog_bus.mem),
        .i_rd_addr (i_peek_addr),
        .o_rd_data (o_peek_data)
    );
endmodule : seprog_top

// ===== rtl/seprog_pkg.sv
package seprog_pkg;
    localparam int ADDR_W        = 6;
    localparam int DATA_W        = 16;
    localparam int DEPTH         = 64;
    localparam int CLK_HZ        = 10_000_000;
    localparam int PROG_TIME_US  = 4000;  // programming_time, typical
    localparam int PROG_MAX_US   = 10000; // programming_time, maximum
    localparam int PROG_CYCLES   = PROG_TIME_US * (CLK_HZ / 1_000_000);
    localparam int PROG_MAX_CYC  = PROG_MAX_US * (CLK_HZ / 1_000_000);
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_DIS  = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL_WORDS = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL_WORDS = 2'h2;
    localparam logic [1:0] EXT_EN   = 2'h3;
    localparam logic [DATA_W-1:0] ERASED = 16'hFFFF;
    typedef enum logic [2:0] {
        SEP_NONE, SEP_WRITE, SEP_ERASE, SEP_WRITE_ALL, SEP_ERASE_ALL
    } seprog_cmd_t;
endpackage : seprog_pkg

// ===== rtl/seprog_prog_if.sv
`timescale 1ns/1ps
// carries one programming job from the command decoder to the array writer
interface seprog_prog_if;
    logic                               start;
    seprog_pkg::seprog_cmd_t            cmd;
    logic [seprog_pkg::ADDR_W-1:0]      addr;
    logic [seprog_pkg::DATA_W-1:0]      data;
    logic                               busy;
    modport ctrl (output start, output cmd, output addr, output data, input busy);
    modport mem  (input start, input cmd, input addr, input data, output busy);
endinterface : seprog_prog_if

// ===== rtl/seprog_array.sv
`timescale 1ns/1ps
// self-timed programming engine holding the nonvolatile word array
module seprog_array #(
    parameter int PROG_CYCLES = seprog_pkg::PROG_CYCLES
) (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst,
    seprog_prog_if.mem                         prog,
    input  wire logic [seprog_pkg::ADDR_W-1:0] i_rd_addr,
    output logic      [seprog_pkg::DATA_W-1:0] o_rd_data
);
    logic [seprog_pkg::DATA_W-1:0] mem_r [seprog_pkg::DEPTH];
    logic [31:0]                   timer_r;
    logic                          busy_r;

    ////////////////////////////////////////////////////////////////////////
    // timer: cycle length fixed, well inside the maximum
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            busy_r  <= 1'b0;
            timer_r <= 32'h0;
        end else if (prog.start && !busy_r) begin
            busy_r  <= 1'b1;
            timer_r <= 32'(PROG_CYCLES - 1);
        end else if (busy_r) begin
            if (timer_r == 32'h0) begin
                busy_r <= 1'b0;
            end else begin
                timer_r <= timer_r - 32'h1;
            end
        end
    end

    // array commits at launch; no reset on storage, like real cells
    always_ff @(posedge i_clock) begin
        if (prog.start && !busy_r) begin
            case (prog.cmd)
                seprog_pkg::SEP_WRITE: begin
                    mem_r[prog.addr] <= prog.data;
                end
                seprog_pkg::SEP_ERASE: begin
                    mem_r[prog.addr] <= seprog_pkg::ERASED;
                end
                seprog_pkg::SEP_WRITE_ALL: begin
                    for (int i = 0; i < seprog_pkg::DEPTH; i++) begin
                        mem_r[i] <= prog.data;
                    end
                end
                seprog_pkg::SEP_ERASE_ALL: begin
                    for (int i = 0; i < seprog_pkg::DEPTH; i++) begin
                        mem_r[i] <= seprog_pkg::ERASED;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign prog.busy = busy_r;
    assign o_rd_data = mem_r[i_rd_addr];
endmodule : seprog_array

// ===== bench/seprog_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// pin-level watch on the program controller
module seprog_checker #(
    parameter int PROG_CYCLES = seprog_pkg::PROG_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_chip_select,
    input wire logic i_serial_clock,
    input wire logic i_serial_data_in,
    input wire logic o_serial_data_out,
    input wire logic o_serial_data_out_oe_n,
    input wire logic o_program_enabled,
    input wire logic o_busy
);
    int busy_cnt_r;
    // counts busy cycles; too many for a repetition operator
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= o_busy ? busy_cnt_r + 1 : 0;
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_prog_length: assert property ($fell(o_busy) |-> busy_cnt_r == PROG_CYCLES)
        else $error("program cycle length wrong");
    chk_prog_bound: assert property (o_busy |-> busy_cnt_r < seprog_pkg::PROG_MAX_CYC)
        else $error("program cycle too long");
    chk_busy_shows_low: assert property (!o_serial_data_out_oe_n && o_busy |-> !o_serial_data_out)
        else $error("busy not shown low");
    chk_ready_shows_high: assert property (!o_serial_data_out_oe_n && !o_busy |-> o_serial_data_out)
        else $error("ready not shown high");
    chk_standby_release: assert property (!i_chip_select [*3] |-> o_serial_data_out_oe_n)
        else $error("output driven in standby");
    chk_launch_on_fall: assert property ($rose(o_busy) |-> !$past(i_chip_select, 2)
        && ($past(i_chip_select, 3) || $past(i_chip_select, 4)))
        else $error("cycle not launched by select fall");
    chk_refuse_disabled: assert property ($rose(o_busy) |-> o_program_enabled)
        else $error("programming while disabled");
    chk_latch_quiet: assert property ($changed(o_program_enabled) |-> !$past(o_busy))
        else $error("latch changed during cycle");
    chk_start_release: assert property ($rose(i_serial_clock) && i_serial_data_in
        && i_chip_select && !o_busy && !o_serial_data_out_oe_n
        |-> ##[1:4] o_serial_data_out_oe_n)
        else $error("output kept after start bit");
    chk_powerup_off: assert property ($fell(i_rst) |-> !o_program_enabled)
        else $error("latch set after reset");
endmodule : seprog_checker
bind seprog_top seprog_checker #(.PROG_CYCLES(PROG_CYCLES)) u_seprog_checker (
    .i_clock(i_clock), .i_rst(i_rst), .i_chip_select(i_chip_select),
    .i_serial_clock(i_serial_clock), .i_serial_data_in(i_serial_data_in),
    .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe_n(o_serial_data_out_oe_n),
    .o_program_enabled(o_program_enabled), .o_busy(o_busy));

// ===== bench/seprog_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// host side of the serial bus; levels move just after i_clock rises
module seprog_host_model (
    input  wire logic i_clock,
    input  wire logic i_serial_data_out,
    input  wire logic i_serial_data_out_oe_n,
    output logic      o_chip_select,
    output logic      o_serial_clock,
    output logic      o_serial_data_in
);
    // serial clock idles low; send pulses it twice with select low before the frame
    initial begin
        o_chip_select = 0;
        o_serial_clock = 0;
        o_serial_data_in = 0;
    end
    task tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    // each level held two system clocks so the sampler cannot miss it
    task pulse(input logic b);
        o_serial_data_in = b;
        o_serial_clock = 0;
        tick(2);
        o_serial_clock = 1;
        tick(2);
    endtask : pulse
    task send(input logic [31:0] bits, input int n, input bit look);
        pulse(1'b1);
        pulse(1'b1);
        o_chip_select = 1;
        if (look) begin
            o_serial_data_in = 0;
            tick(3);
            pulse(1'b0);
            pulse(1'b0);
        end
        for (int i = n - 1; i >= 0; i--) pulse(bits[i]);
        o_serial_clock = 0;
        tick(2);
        o_chip_select = 0;
        o_serial_data_in = 0;
        tick(2);
    endtask : send
    task poll(output logic dv, output logic ov);
        o_serial_data_in = 0;
        o_chip_select = 1;
        tick(3);
        dv = i_serial_data_out;
        ov = i_serial_data_out_oe_n;
        o_chip_select = 0;
        tick(2);
    endtask : poll
endmodule : seprog_host_model

// ===== bench/serial_eeprom_program_control_tb_top.sv
`timescale 1ns/1ps
module serial_eeprom_program_control_tb_top;
    localparam int PC = 200; // short cycle keeps the run brief
    logic        clk, rst, cs, sk, di, dout, oen, en, busy;
    logic [5:0]  pa;
    logic [15:0] pd;
    logic [15:0] mem [64];
    int          errors, n_checks, seed;
    bit          men, known;
    seprog_top #(.PROG_CYCLES(PC)) u_seprog_top (
        .i_clock(clk), .i_rst(rst), .i_chip_select(cs), .i_serial_clock(sk),
        .i_serial_data_in(di), .o_serial_data_out(dout), .o_serial_data_out_oe_n(oen),
        .o_program_enabled(en), .o_busy(busy), .i_peek_addr(pa), .o_peek_data(pd));
    seprog_host_model u_seprog_host_model (
        .i_clock(clk), .i_serial_data_out(dout), .i_serial_data_out_oe_n(oen),
        .o_chip_select(cs), .o_serial_clock(sk), .o_serial_data_in(di));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // poll until ready; the first poll must still see busy
    task wait_ready();
        logic dv, ov;
        for (int k = 0; k < 100; k++) begin
            u_seprog_host_model.poll(dv, ov);
            check("poll oe_n", 16'(ov), 16'h0);
            if (k == 0) check("poll busy", 16'(dv), 16'h0);
            if (dv === 1'b1) return;
        end
        errors++;
        results();
    endtask : wait_ready
    task automatic run(input logic [1:0] op, input logic [5:0] a, input logic [19:0] d,
                       input int nd, input bit look, input bit inj);
        bit x, wr, prog;
        logic [1:0] e;
        x = op == seprog_pkg::OP_EXT;
        e = a[5:4];
        // only nd data bits go on the wire; upper bits of d must not land on the address
        u_seprog_host_model.send(({23'h0, 1'b1, op, a} << nd)
                                 | ({12'h0, d} & ~(32'hFFFFFFFF << nd)), 9 + nd, look);
        if (x && e == seprog_pkg::EXT_EN) men = 1;
        if (x && e == seprog_pkg::EXT_DIS) men = 0;
        wr = op == seprog_pkg::OP_WRITE || (x && e == seprog_pkg::EXT_WRITE_ALL_WORDS);
        prog = men && (wr || op == seprog_pkg::OP_ERASE || (x && e == seprog_pkg::EXT_ERASE_ALL_WORDS));
        known |= prog && x;
        for (int i = 0; i < 64; i++)
            if (prog && (x || i == a)) mem[i] = wr ? d[15:0] : 16'hFFFF;
        u_seprog_host_model.tick(2);
        check("busy", 16'(busy), 16'(prog));
        if (inj) u_seprog_host_model.send({23'h0, 9'h100}, 9, 0);
        if (prog) wait_ready();
        check("latch", 16'(en), 16'(men));
        for (int i = 0; i < 64 && known; i++) begin
            pa = 6'(i);
            u_seprog_host_model.tick(1);
            check("word", pd, mem[i]);
        end
        $display("instruction %h %h done", op, a);
    endtask : run
    initial begin
        seed = 93;
        rst = 1;
        pa = 0;
        repeat (5) @(posedge clk);
        #1 rst = 0;
        u_seprog_host_model.tick(1);
        check("latch at reset", 16'(en), 16'h0);
        run(seprog_pkg::OP_WRITE, 6'($random(seed)), 20'h0, 16, 0, 0);
        run(seprog_pkg::OP_EXT, 6'h30, 20'h0, 0, 0, 0);
        run(seprog_pkg::OP_READ, 6'($random(seed)), 20'h0, 0, 0, 0);
        run(seprog_pkg::OP_EXT, 6'h20 | 6'($random(seed) & 15), 20'h0, 0, 0, 0);
        run(seprog_pkg::OP_WRITE, 6'($random(seed)), 20'($random(seed)), 16, 1, 0);
        run(seprog_pkg::OP_WRITE, 6'($random(seed)), 20'($random(seed)), 20, 1, 1);
        run(seprog_pkg::OP_ERASE, 6'($random(seed)), 20'h0, 0, 1, 0);
        run(seprog_pkg::OP_EXT, 6'h10 | 6'($random(seed) & 15), 20'($random(seed)), 16, 1, 0);
        run(seprog_pkg::OP_WRITE, 6'($random(seed)), 20'($random(seed)), 16, 1, 0);
        run(seprog_pkg::OP_EXT, 6'h00, 20'h0, 0, 1, 0);
        run(seprog_pkg::OP_WRITE, 6'($random(seed)), 20'($random(seed)), 16, 0, 0);
        run(seprog_pkg::OP_EXT, 6'h20, 20'h0, 0, 0, 0);
        results();
    end
endmodule : serial_eeprom_program_control_tb_top
